//--- common/odmp_params.svh
// offsets, field positions, reset values and timing counts of the mpu port
`ifndef ODMP_PARAMS_SVH
`define ODMP_PARAMS_SVH

// ----------------------------------------------------------------------
// interface strap codes, ordered {bit0, bit1, bit2}
// ----------------------------------------------------------------------
`define ODMP_IM_6800    3'h1
`define ODMP_IM_8080    3'h3
`define ODMP_IM_SPI4    3'h0
`define ODMP_IM_SPI3    3'h4
`define ODMP_IM_I2C     3'h2

// ----------------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------------
`define ODMP_PTR_W      13
`define ODMP_OSC_DIV    8

// ----------------------------------------------------------------------
// synchroniser vector layout
// ----------------------------------------------------------------------
`define ODMP_SYNC_W     18
`define ODMP_POS_DATA   0
`define ODMP_POS_CS     8
`define ODMP_POS_DC     9
`define ODMP_POS_WR     10
`define ODMP_POS_RD     11
`define ODMP_POS_IM0    12
`define ODMP_POS_IM1    13
`define ODMP_POS_IM2    14
`define ODMP_POS_OSC    15
`define ODMP_POS_CLK    16
`define ODMP_POS_RST    17
`define ODMP_SYNC_RST   18'h00d00

`endif

//--- common/odmp_pkg.sv
// types of the mpu port
package odmp_pkg;

   // ----------------------------------------------------------------------
   // interface mode
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ODMP_MODE_NONE,
      ODMP_MODE_6800,
      ODMP_MODE_8080,
      ODMP_MODE_SPI4,
      ODMP_MODE_SPI3,
      ODMP_MODE_I2C
   } odmp_mode_t;

   // ----------------------------------------------------------------------
   // decoded bus function
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ODMP_FN_IDLE,
      ODMP_FN_DATA_RD,
      ODMP_FN_DATA_WR,
      ODMP_FN_STATUS_RD,
      ODMP_FN_CMD_WR
   } odmp_fn_t;

endpackage

//--- rtl/odmp_sync.sv
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps

module odmp_sync #(
   parameter int                 WIDTH   = 1,
   parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // pins and synchronised copy
   input  wire logic [WIDTH-1:0] din_i,
   output logic      [WIDTH-1:0] dout_o
);

   logic [WIDTH-1:0] meta_q;

   // ----------------------------------------------------------------------
   // two stages
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= RST_VAL;
         dout_o <= RST_VAL;
      end else begin
         meta_q <= din_i;
         dout_o <= meta_q;
      end
   end

endmodule

//--- rtl/odmp_clkgen.sv
// display clock source: internal oscillator or external clock pin
`timescale 1ns/1ps

module odmp_clkgen #(
   parameter int DIV = 8
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // selection and external clock, both already synchronised
   input  wire logic osc_en_i,
   input  wire logic ext_clk_i,
   // pin drive and display tick
   output logic      clk_o,
   output logic      clk_oe_o,
   output logic      tick_o
);

   localparam int             CW   = $clog2(DIV + 1);
   localparam logic [CW-1:0]  LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          osc_d;
   logic          oe_d;
   logic          tick_d;
   logic          ext_prev_q;
   logic          wrap;

   // ----------------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------------
   always_comb begin
      wrap   = (cnt_q == LAST);
      cnt_d  = '0;
      osc_d  = 1'b0;
      oe_d   = osc_en_i;
      tick_d = ext_clk_i & ~ext_prev_q;
      if (osc_en_i) begin
         cnt_d  = wrap ? '0 : cnt_q + 1'b1;
         osc_d  = wrap ? ~clk_o : clk_o;
         tick_d = wrap & ~clk_o;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q      <= '0;
         clk_o      <= 1'b0;
         clk_oe_o   <= 1'b0;
         tick_o     <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         clk_o      <= osc_d;
         clk_oe_o   <= oe_d;
         tick_o     <= tick_d;
         ext_prev_q <= ext_clk_i;
      end
   end

endmodule

//--- rtl/odmp_port.sv
// parallel microprocessor port of the display driver
`timescale 1ns/1ps
`include "odmp_params.svh"

module odmp_port #(
   parameter int PTR_W   = `ODMP_PTR_W,
   parameter int OSC_DIV = `ODMP_OSC_DIV
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   // straps and reset pin
   input  wire logic              iface_sel_bit0_i,
   input  wire logic              iface_sel_bit1_i,
   input  wire logic              iface_sel_bit2_i,
   input  wire logic              osc_enable_strap_i,
   input  wire logic              reset_n_in_i,
   // host bus
   input  wire logic              cs_n_i,
   input  wire logic              data_cmd_sel_i,
   input  wire logic              wr_n_i,
   input  wire logic              rd_n_i,
   input  wire logic [7:0]        data_i,
   output logic      [7:0]        data_o,
   output logic      [7:0]        data_oe_o,
   // display clock pin
   input  wire logic              display_clock_pin_i,
   output logic                   display_clock_pin_o,
   output logic                   display_clock_pin_oe_o,
   output logic                   disp_tick_o,
   // serial front end
   output odmp_pkg::odmp_mode_t   mode_o,
   output logic                   serial_clk_o,
   output logic                   serial_data_o,
   // command side
   output logic                   cmd_wr_o,
   output logic      [7:0]        cmd_byte_o,
   output logic                   settings_reset_o,
   input  wire logic [7:0]        status_i,
   // display ram side
   output logic                   ram_we_o,
   output logic                   ram_re_o,
   output logic      [PTR_W-1:0]  ram_addr_o,
   output logic      [7:0]        ram_wdata_o,
   input  wire logic [7:0]        ram_rdata_i,
   input  wire logic              ptr_load_i,
   input  wire logic [PTR_W-1:0]  ptr_value_i
);

   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic [`ODMP_SYNC_W-1:0] pins;
   logic [`ODMP_SYNC_W-1:0] sync_s;
   logic [7:0]              data_s;
   logic                    cs_s;
   logic                    dc_s;
   logic                    wr_s;
   logic                    rd_s;
   logic [2:0]              im_s;
   logic                    osc_s;
   logic                    clk_s;
   logic                    rst_ok;

   assign pins = {reset_n_in_i, display_clock_pin_i, osc_enable_strap_i,
                  iface_sel_bit2_i, iface_sel_bit1_i, iface_sel_bit0_i,
                  rd_n_i, wr_n_i, data_cmd_sel_i, cs_n_i, data_i};

   odmp_sync #(
      .WIDTH   (`ODMP_SYNC_W),
      .RST_VAL (`ODMP_SYNC_RST)
   ) u_sync (
      .clk_i   (ref_clk_i),
      .reset_i (reset_i),
      .din_i   (pins),
      .dout_o  (sync_s)
   );

   assign data_s = sync_s[`ODMP_POS_DATA +: 8];
   assign cs_s   = sync_s[`ODMP_POS_CS];
   assign dc_s   = sync_s[`ODMP_POS_DC];
   assign wr_s   = sync_s[`ODMP_POS_WR];
   assign rd_s   = sync_s[`ODMP_POS_RD];
   assign im_s   = {sync_s[`ODMP_POS_IM0], sync_s[`ODMP_POS_IM1], sync_s[`ODMP_POS_IM2]};
   assign osc_s  = sync_s[`ODMP_POS_OSC];
   assign clk_s  = sync_s[`ODMP_POS_CLK];
   assign rst_ok = sync_s[`ODMP_POS_RST];

   // ----------------------------------------------------------------------
   // display clock
   // ----------------------------------------------------------------------
   odmp_clkgen #(
      .DIV       (OSC_DIV)
   ) u_clkgen (
      .clk_i     (ref_clk_i),
      .reset_i   (reset_i),
      .osc_en_i  (osc_s),
      .ext_clk_i (clk_s),
      .clk_o     (display_clock_pin_o),
      .clk_oe_o  (display_clock_pin_oe_o),
      .tick_o    (disp_tick_o)
   );

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic                 wr_prev_q;
   logic                 rd_prev_q;
   logic [PTR_W-1:0]     ptr_q;
   logic [PTR_W-1:0]     ptr_d;
   logic [7:0]           rbuf_q;
   logic [7:0]           rbuf_d;
   odmp_pkg::odmp_mode_t mode_d;
   odmp_pkg::odmp_fn_t   fn_c;
   logic                 is6800;
   logic                 is8080;
   logic                 is_serial;
   logic                 sel;
   logic                 drive;
   logic [7:0]           data_d;
   logic [7:0]           oe_d;
   logic                 cmd_wr_d;
   logic [7:0]           cmd_byte_d;
   logic                 ram_we_d;
   logic                 ram_re_d;
   logic [PTR_W-1:0]     ram_addr_d;
   logic [7:0]           ram_wdata_d;
   logic                 sclk_d;
   logic                 sdat_d;

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   always_comb begin
      case (im_s)
         `ODMP_IM_6800: mode_d = odmp_pkg::ODMP_MODE_6800;
         `ODMP_IM_8080: mode_d = odmp_pkg::ODMP_MODE_8080;
         `ODMP_IM_SPI4: mode_d = odmp_pkg::ODMP_MODE_SPI4;
         `ODMP_IM_SPI3: mode_d = odmp_pkg::ODMP_MODE_SPI3;
         `ODMP_IM_I2C:  mode_d = odmp_pkg::ODMP_MODE_I2C;
         default:       mode_d = odmp_pkg::ODMP_MODE_NONE;
      endcase
   end

   // ----------------------------------------------------------------------
   // function decode and next values
   // ----------------------------------------------------------------------
   always_comb begin
      is6800    = (mode_o == odmp_pkg::ODMP_MODE_6800);
      is8080    = (mode_o == odmp_pkg::ODMP_MODE_8080);
      is_serial = (mode_o == odmp_pkg::ODMP_MODE_SPI4) ||
                  (mode_o == odmp_pkg::ODMP_MODE_SPI3) ||
                  (mode_o == odmp_pkg::ODMP_MODE_I2C);
      sel       = ~cs_s & rst_ok;
      fn_c      = odmp_pkg::ODMP_FN_IDLE;
      if (sel && is8080) begin
         if (wr_s && !wr_prev_q) begin
            fn_c = dc_s ? odmp_pkg::ODMP_FN_DATA_WR : odmp_pkg::ODMP_FN_CMD_WR;
         end else if (!rd_s && rd_prev_q) begin
            fn_c = dc_s ? odmp_pkg::ODMP_FN_DATA_RD : odmp_pkg::ODMP_FN_STATUS_RD;
         end
      end else if (sel && is6800) begin
         if (!rd_s && rd_prev_q && !wr_s) begin
            fn_c = dc_s ? odmp_pkg::ODMP_FN_DATA_WR : odmp_pkg::ODMP_FN_CMD_WR;
         end else if (rd_s && !rd_prev_q && wr_s) begin
            fn_c = dc_s ? odmp_pkg::ODMP_FN_DATA_RD : odmp_pkg::ODMP_FN_STATUS_RD;
         end
      end
      // bus direction
      drive = sel && ((is8080 && !rd_s) || (is6800 && rd_s && wr_s));
      oe_d  = {8{drive}};
      // defaults: strobes low, read buffer loads ram data after a ram read, others hold
      data_d      = data_o;
      cmd_wr_d    = 1'b0;
      cmd_byte_d  = cmd_byte_o;
      ram_we_d    = 1'b0;
      ram_re_d    = 1'b0;
      ram_addr_d  = ram_addr_o;
      ram_wdata_d = ram_wdata_o;
      ptr_d       = ptr_q;
      rbuf_d      = ram_re_o ? ram_rdata_i : rbuf_q;
      case (fn_c)
         odmp_pkg::ODMP_FN_DATA_WR: begin
            ram_we_d    = 1'b1;
            ram_addr_d  = ptr_q;
            ram_wdata_d = data_s;
            ptr_d       = ptr_q + 1'b1;
         end
         odmp_pkg::ODMP_FN_CMD_WR: begin
            cmd_wr_d   = 1'b1;
            cmd_byte_d = data_s;
         end
         odmp_pkg::ODMP_FN_DATA_RD: begin
            data_d     = rbuf_q;
            ram_re_d   = 1'b1;
            ram_addr_d = ptr_q;
            ptr_d      = ptr_q + 1'b1;
         end
         odmp_pkg::ODMP_FN_STATUS_RD: begin
            data_d = status_i;
         end
         default: begin
            data_d = data_o;
         end
      endcase
      if (ptr_load_i) begin
         ptr_d = ptr_value_i;
      end
      // serial front end pins
      sclk_d = is_serial & data_s[0];
      sdat_d = is_serial & data_s[1];
      if (!rst_ok) begin
         ptr_d       = '0;
         rbuf_d      = 8'h00;
         data_d      = 8'h00;
         cmd_byte_d  = 8'h00;
         ram_addr_d  = '0;
         ram_wdata_d = 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_o           <= odmp_pkg::ODMP_MODE_NONE;
         wr_prev_q        <= 1'b1;
         rd_prev_q        <= 1'b1;
         ptr_q            <= '0;
         rbuf_q           <= 8'h00;
         data_o           <= 8'h00;
         data_oe_o        <= 8'h00;
         cmd_wr_o         <= 1'b0;
         cmd_byte_o       <= 8'h00;
         settings_reset_o <= 1'b1;
         ram_we_o         <= 1'b0;
         ram_re_o         <= 1'b0;
         ram_addr_o       <= '0;
         ram_wdata_o      <= 8'h00;
         serial_clk_o     <= 1'b0;
         serial_data_o    <= 1'b0;
      end else begin
         mode_o           <= mode_d;
         wr_prev_q        <= wr_s;
         rd_prev_q        <= rd_s;
         ptr_q            <= ptr_d;
         rbuf_q           <= rbuf_d;
         data_o           <= data_d;
         data_oe_o        <= oe_d;
         cmd_wr_o         <= cmd_wr_d;
         cmd_byte_o       <= cmd_byte_d;
         settings_reset_o <= ~rst_ok;
         ram_we_o         <= ram_we_d;
         ram_re_o         <= ram_re_d;
         ram_addr_o       <= ram_addr_d;
         ram_wdata_o      <= ram_wdata_d;
         serial_clk_o     <= sclk_d;
         serial_data_o    <= sdat_d;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_hiz_deselected;
      @(posedge ref_clk_i) disable iff (reset_i)
      cs_s |=> (data_oe_o == 8'h00) && !ram_we_o && !cmd_wr_o;
   endproperty
   a_hiz_deselected: assert property (p_hiz_deselected)
      else $error("bus driven or transfer while deselected");

   property p_reset_pin;
      @(posedge ref_clk_i) disable iff (reset_i)
      !rst_ok |=> settings_reset_o && (ptr_q == '0) && (data_oe_o == 8'h00);
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset pin level did not initialize state");

   property p_data_write;
      @(posedge ref_clk_i) disable iff (reset_i)
      (fn_c == odmp_pkg::ODMP_FN_DATA_WR) |=>
         ram_we_o && !cmd_wr_o && (ram_wdata_o == $past(data_s));
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("display data write not delivered");

   property p_8080_write;
      @(posedge ref_clk_i) disable iff (reset_i)
      (is8080 && sel && wr_s && !wr_prev_q && !dc_s) |=>
         cmd_wr_o && !ram_we_o && (cmd_byte_o == $past(data_s));
   endproperty
   a_8080_write: assert property (p_8080_write)
      else $error("8080 command write not captured at strobe rise");

   property p_6800_read_drive;
      @(posedge ref_clk_i) disable iff (reset_i)
      (is6800 && sel && rd_s && wr_s) |=> (data_oe_o == 8'hff);
   endproperty
   a_6800_read_drive: assert property (p_6800_read_drive)
      else $error("6800 read did not drive the bus");

   property p_6800_latch;
      @(posedge ref_clk_i) disable iff (reset_i)
      (is6800 && sel && !rd_s && rd_prev_q && !wr_s) |=> (ram_we_o ^ cmd_wr_o);
   endproperty
   a_6800_latch: assert property (p_6800_latch)
      else $error("6800 enable fall produced no single write");

   property p_8080_drive;
      @(posedge ref_clk_i) disable iff (reset_i)
      (is8080 && sel && !rd_s) |=> (data_oe_o == 8'hff);
   endproperty
   a_8080_drive: assert property (p_8080_drive)
      else $error("8080 read strobe low but bus not driven");

   property p_prefetch;
      @(posedge ref_clk_i) disable iff (reset_i)
      (fn_c == odmp_pkg::ODMP_FN_DATA_RD) |=> ram_re_o && (data_o == $past(rbuf_q));
   endproperty
   a_prefetch: assert property (p_prefetch)
      else $error("display read did not return prefetched byte");

   property p_status;
      @(posedge ref_clk_i) disable iff (reset_i)
      (fn_c == odmp_pkg::ODMP_FN_STATUS_RD) |=> !ram_re_o && (data_o == $past(status_i));
   endproperty
   a_status: assert property (p_status)
      else $error("status read returned wrong byte");

   property p_serial;
      @(posedge ref_clk_i) disable iff (reset_i)
      is_serial |=> (data_oe_o == 8'h00) && (serial_clk_o == $past(data_s[0]));
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial mode pin use wrong");

   property p_clk_dir;
      @(posedge ref_clk_i) disable iff (reset_i)
      1'b1 |=> (display_clock_pin_oe_o == $past(osc_s));
   endproperty
   a_clk_dir: assert property (p_clk_dir)
      else $error("display clock pin direction wrong");

   property p_one_transfer;
      @(posedge ref_clk_i) disable iff (reset_i)
      (ram_we_o || cmd_wr_o) |=> !ram_we_o && !cmd_wr_o;
   endproperty
   a_one_transfer: assert property (p_one_transfer)
      else $error("one strobe produced two transfers");

   property p_ptr_step;
      @(posedge ref_clk_i) disable iff (reset_i)
      (ram_we_o || ram_re_o) && !$past(ptr_load_i) |-> ptr_q == PTR_W'(ram_addr_o + 1'b1);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("ram pointer did not advance");

   c_8080_data_wr: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      is8080 && (fn_c == odmp_pkg::ODMP_FN_DATA_WR));
   c_6800_cmd_wr: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      is6800 && (fn_c == odmp_pkg::ODMP_FN_CMD_WR));
   c_dummy_then_read: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      ram_re_o ##[1:40] (fn_c == odmp_pkg::ODMP_FN_DATA_RD));
   c_status_rd: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      (fn_c == odmp_pkg::ODMP_FN_STATUS_RD));

endmodule

//--- bench/odmp_host.sv
// host bus model: 6800 or 8080 style microprocessor
`timescale 1ns/1ps

module odmp_host (
   // clock
   input  wire logic       clk_i,
   // bus
   input  wire logic [7:0] bus_i,
   output logic            cs_n_o,
   output logic            dc_o,
   output logic            wr_n_o,
   output logic            rd_n_o,
   output logic      [7:0] data_o
);
   // -----------------
   // bus cycles
   // -----------------
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task put(input logic [7:0] d);
      data_o = d;
   endtask

   // idle levels first, then select, strobe 5 cycles, hold 5 cycles
   task xfer(input logic m, rd, dc, csh, input logic [7:0] d, output logic [7:0] q);
      cyc(1);
      rd_n_o = ~m;
      wr_n_o = m ? rd : 1'b1;
      dc_o   = dc;
      data_o = rd ? ~data_o : d;
      cyc(1);
      cs_n_o = csh;
      cyc(1);
      if (m) rd_n_o = 1'b1;
      else if (rd) rd_n_o = 1'b0;
      else wr_n_o = 1'b0;
      cyc(5);
      q      = bus_i;
      rd_n_o = ~m;
      wr_n_o = m ? rd : 1'b1;
      cyc(5);
      cs_n_o = 1'b1;
      data_o = ~data_o;
   endtask

   initial begin
      cs_n_o = 1'b1;
      dc_o   = 1'b0;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      data_o = 8'h00;
   end
endmodule

//--- bench/tb.sv
// self-checking bench of the parallel mpu port
`timescale 1ns/1ps
`include "odmp_params.svh"

module tb;
   typedef struct packed {
      logic        m;
      logic        rd;
      logic        dc;
      logic [7:0]  d;
      logic [15:0] e;
   } odmp_row_t;
   // -----------------
   // signals
   // -----------------
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic [2:0]           im;
   logic                 osc;
   logic                 rstn_pin;
   logic                 ext_clk;
   logic                 ld;
   logic [7:0]           status;
   logic [12:0]          ptrv;
   int                   nre = 0;
   int                   nhi = 0;
   wire                  ram_re, dclk;
   logic [7:0]           q;
   logic [15:0]          seen_w;
   int                   err_count = 0;
   int                   comparisons = 0;
   int                   npulse = 0;
   int                   ntick = 0;
   int                   noe = 0;
   int                   n0;
   wire                  cs_n, dc, wr_n, rd_n;
   wire  [7:0]           hdata, bus, dout, doe, cbyte, wdata;
   wire                  clk_oe, tick, sclk, sdat, cmd_wr, srst, ram_we;
   wire  [12:0]          addr;
   odmp_pkg::odmp_mode_t mode;
   odmp_row_t            rows [10] = '{
      '{0, 0, 0, 8'hae, 16'h00ae}, '{0, 0, 1, 8'h11, 16'h0011},
      '{0, 0, 1, 8'h22, 16'h0122}, '{0, 1, 0, 8'h00, 16'h003c},
      '{0, 1, 1, 8'h00, 16'h0000}, '{0, 1, 1, 8'h00, 16'h0058},
      '{1, 0, 1, 8'h77, 16'h0477}, '{1, 0, 0, 8'hc3, 16'h00c3},
      '{1, 1, 0, 8'h00, 16'h003c}, '{1, 1, 1, 8'h00, 16'h0059}};
   logic [2:0]           codes [5] = '{`ODMP_IM_6800, `ODMP_IM_8080, `ODMP_IM_I2C,
                                       `ODMP_IM_SPI3, `ODMP_IM_SPI4};
   odmp_pkg::odmp_mode_t modes [5] = '{odmp_pkg::ODMP_MODE_6800, odmp_pkg::ODMP_MODE_8080,
      odmp_pkg::ODMP_MODE_I2C, odmp_pkg::ODMP_MODE_SPI3, odmp_pkg::ODMP_MODE_SPI4};

   assign bus = (doe & dout) | (~doe & hdata);
   always #2.5 clk = ~clk;

   odmp_host HOST (.clk_i(clk), .bus_i(bus), .cs_n_o(cs_n), .dc_o(dc), .wr_n_o(wr_n),
                   .rd_n_o(rd_n), .data_o(hdata));

   odmp_port #(.PTR_W(13), .OSC_DIV(8)) DUT (
      .ref_clk_i(clk), .reset_i(rst), .iface_sel_bit0_i(im[2]), .iface_sel_bit1_i(im[1]),
      .iface_sel_bit2_i(im[0]), .osc_enable_strap_i(osc), .reset_n_in_i(rstn_pin),
      .cs_n_i(cs_n), .data_cmd_sel_i(dc), .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(bus),
      .data_o(dout), .data_oe_o(doe), .display_clock_pin_i(ext_clk),
      .display_clock_pin_o(dclk), .display_clock_pin_oe_o(clk_oe), .disp_tick_o(tick),
      .mode_o(mode), .serial_clk_o(sclk), .serial_data_o(sdat), .cmd_wr_o(cmd_wr),
      .cmd_byte_o(cbyte), .settings_reset_o(srst), .status_i(status), .ram_we_o(ram_we),
      .ram_re_o(ram_re), .ram_addr_o(addr), .ram_wdata_o(wdata),
      .ram_rdata_i(addr[7:0] ^ 8'h5a), .ptr_load_i(ld), .ptr_value_i(ptrv));

   // -----------------
   // monitor and checks
   // -----------------
   always @(posedge clk) begin
      if (ram_we) seen_w = {addr[7:0], wdata};
      if (cmd_wr) seen_w = {8'h00, cbyte};
      if (ram_we || cmd_wr) npulse++;
      if (tick) ntick++;
      if (|doe) noe++;
      if (ram_re) nre++;
      if (dclk) nhi++;
   end

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      stop_test;
   end

   // -----------------
   // main sequence
   // -----------------
   initial begin
      im       = `ODMP_IM_8080;
      osc      = 1'b1;
      rstn_pin = 1'b1;
      ext_clk  = 1'b0;
      ld       = 1'b0;
      status   = 8'h3c;
      ptrv     = 13'h0a5;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      HOST.cyc(8);
      foreach (rows[i]) begin
         if (i == 6) im = `ODMP_IM_6800;
         n0 = npulse;
         HOST.xfer(rows[i].m, rows[i].rd, rows[i].dc, 1'b0, rows[i].d, q);
         chk(rows[i].rd ? {8'h00, q} : seen_w, rows[i].e);
         chk(16'(npulse - n0), rows[i].rd ? 16'h0000 : 16'h0001);
         chk(16'(doe), 16'h0000);
      end
      chk(16'(nre), 16'h0003);
      rstn_pin = 1'b0;
      HOST.cyc(6);
      chk(16'(srst), 16'h0001);
      n0 = npulse;
      HOST.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h99, q);
      chk(16'(npulse - n0), 16'h0000);
      rstn_pin = 1'b1;
      HOST.cyc(6);
      chk(16'(srst), 16'h0000);
      HOST.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h44, q);
      chk(seen_w, 16'h0044);
      ld = 1'b1;
      HOST.cyc(1);
      ld = 1'b0;
      HOST.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h66, q);
      chk(seen_w, 16'ha566);
      n0 = npulse + noe;
      HOST.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'h55, q);
      HOST.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, q);
      chk(16'(npulse + noe - n0), 16'h0000);
      n0 = ntick;
      nhi = 0;
      HOST.cyc(64);
      chk(16'(ntick - n0), 16'h0004);
      chk(16'(nhi), 16'h0020);
      chk(16'(clk_oe), 16'h0001);
      osc = 1'b0;
      HOST.cyc(8);
      chk(16'(clk_oe), 16'h0000);
      n0 = ntick;
      repeat (3) begin
         ext_clk = 1'b1;
         HOST.cyc(4);
         ext_clk = 1'b0;
         HOST.cyc(4);
      end
      HOST.cyc(4);
      chk(16'(ntick - n0), 16'h0003);
      foreach (codes[i]) begin
         im = codes[i];
         HOST.cyc(6);
         chk(16'(mode), 16'(modes[i]));
      end
      HOST.put(8'h01);
      HOST.cyc(6);
      chk({14'h0000, sclk, sdat}, 16'h0002);
      HOST.put(8'h02);
      HOST.cyc(6);
      chk({14'h0000, sclk, sdat}, 16'h0001);
      n0 = noe;
      HOST.xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
      chk(16'(noe - n0), 16'h0000);
      stop_test;
   end
endmodule
